// file: apar_top.sv
// apar_top: analog port alarm routing, standby action and DC output state
// assumes external pins are asynchronous; configuration ports from local logic
`timescale 1ns/1ps
module apar_top (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // configuration writes, accepted only while output is off
   input  wire logic       cfg_we,
   input  wire logic [1:0] cfg_a1_sel,
   input  wire logic [2:0] cfg_a2_mask,
   input  wire logic       cfg_st_sel,
   input  wire logic       cfg_sb_action,
   input  wire logic       cfg_pu_policy,
   // control from other locations and power-up
   input  wire logic       local_on_req,
   input  wire logic       local_off_req,
   input  wire logic       analog_remote,
   input  wire logic       power_up,
   input  wire logic       last_dc_state,
   // pins and alarm sources
   input  wire logic       remote_standby_input,
   input  wire logic       overtemperature_alarm,
   input  wire logic       power_fail_alarm,
   input  wire logic       overvoltage_alarm,
   input  wire logic       overcurrent_alarm,
   input  wire logic       overpower_alarm,
   input  wire logic       constant_voltage_regulation,
   // outputs
   output logic            dc_on_q,
   output logic            alarm1_q,
   output logic            alarm2_q,
   output logic            status3_q,
   output logic            cfg_locked_q,
   output logic            cfg_reject_q
);
   localparam int NSYNC = 7;

   apar_cfg_if cfg ();
   apar_pkg::apar_sb_action_e sb_action_q;
   apar_pkg::apar_pu_e        pu_q;
   logic [NSYNC-1:0]          s1_q;
   logic [NSYNC-1:0]          s2_q;
   logic                      sb_prev_q;
   logic                      was_on_q;
   logic                      a1_d;
   logic                      a2_d;
   logic                      st_d;
   logic                      sb;
   logic                      sb_rise;
   logic                      sb_fall;
   logic                      cfg_ok;

   // two-stage synchronisers for all pin inputs
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {constant_voltage_regulation, overpower_alarm, overcurrent_alarm,
                  overvoltage_alarm, power_fail_alarm, overtemperature_alarm,
                  remote_standby_input};
         s2_q <= s1_q;
      end
   end

   assign sb      = s2_q[0];
   assign sb_rise = sb & ~sb_prev_q;
   assign sb_fall = ~sb & sb_prev_q;
   assign cfg_ok  = cfg_we & ~dc_on_q;

   // configuration, writable only while the output is off
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg.a1_sel  <= apar_pkg::APAR_A1_RESET;
         cfg.a2_mask <= apar_pkg::APAR_A2_RESET;
         cfg.st_sel  <= apar_pkg::APAR_ST_RESET;
         sb_action_q <= apar_pkg::APAR_SB_RESET;
         pu_q        <= apar_pkg::APAR_PU_RESET;
      end else if (cfg_ok) begin
         // code 3 of the first selector is illegal and keeps the old choice
         if (cfg_a1_sel != 2'h3)
            cfg.a1_sel <= apar_pkg::apar_a1_sel_e'(cfg_a1_sel);
         // the empty subset is not one of the seven settings
         if (cfg_a2_mask != 3'h0)
            cfg.a2_mask <= cfg_a2_mask;
         cfg.st_sel  <= apar_pkg::apar_st_sel_e'(cfg_st_sel);
         sb_action_q <= apar_pkg::apar_sb_action_e'(cfg_sb_action);
         pu_q        <= apar_pkg::apar_pu_e'(cfg_pu_policy);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_locked_q <= 1'b0;
         cfg_reject_q <= 1'b0;
      end else begin
         cfg_locked_q <= dc_on_q;
         cfg_reject_q <= cfg_we & dc_on_q;
      end
   end

   // DC output stage state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dc_on_q   <= 1'b0;
         was_on_q  <= 1'b0;
         sb_prev_q <= 1'b0;
      end else begin
         sb_prev_q <= sb;
         if (power_up) begin
            dc_on_q  <= (pu_q == apar_pkg::APAR_PU_RESTORE) & last_dc_state;
            was_on_q <= 1'b0;
         end else if (local_off_req) begin
            dc_on_q  <= 1'b0;
            was_on_q <= 1'b0;
         end else if (local_on_req) begin
            dc_on_q  <= 1'b1;
            was_on_q <= 1'b1;
         end else if (!analog_remote && sb_rise) begin
            dc_on_q  <= 1'b0;
         end else if (!analog_remote && sb_fall && was_on_q &&
                      sb_action_q == apar_pkg::APAR_SB_ON_OFF) begin
            dc_on_q  <= 1'b1;
         end
      end
   end

   apar_mux u_mux (
      .cfg      (cfg),
      .temp_alm (s2_q[1]),
      .pwr_alm  (s2_q[2]),
      .ov       (s2_q[3]),
      .oc       (s2_q[4]),
      .op       (s2_q[5]),
      .volt_reg (s2_q[6]),
      .dc_on    (dc_on_q),
      .a1       (a1_d),
      .a2       (a2_d),
      .st       (st_d)
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         alarm1_q  <= 1'b0;
         alarm2_q  <= 1'b0;
         status3_q <= 1'b0;
      end else begin
         alarm1_q  <= a1_d;
         alarm2_q  <= a2_d;
         status3_q <= st_d;
      end
   end

   // checks
   sb_no_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !dc_on_q && !local_on_req && !power_up && sb_action_q == apar_pkg::APAR_SB_OFF_ONLY
      |=> !dc_on_q) else $error("standby input switched output on");
   sb_restore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(dc_on_q) && !$past(local_on_req) && !$past(power_up) |-> $past(was_on_q))
      else $error("standby restored an output never switched on");
   a1_both_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cfg.a1_sel == apar_pkg::APAR_A1_BOTH |=> alarm1_q == $past(s2_q[1] | s2_q[2]))
      else $error("first alarm not OR of both");
   a1_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cfg.a1_sel == apar_pkg::APAR_A1_TEMP |=> alarm1_q == $past(s2_q[1]))
      else $error("first alarm selection wrong");
   a2_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cfg.a2_mask != 3'h0) else $error("second alarm selection empty");
   a2_or_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> alarm2_q == $past(|(cfg.a2_mask & s2_q[5:3])))
      else $error("second alarm not OR of selection");
   st_cv_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cfg.st_sel == apar_pkg::APAR_ST_REGULATION |=> status3_q == $past(s2_q[6]))
      else $error("third status not regulation mode");
   st_dc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cfg.st_sel == apar_pkg::APAR_ST_DC_STATUS |=> status3_q == $past(dc_on_q))
      else $error("third status not output state");
   pu_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      power_up && pu_q == apar_pkg::APAR_PU_OFF |=> !dc_on_q)
      else $error("output on after power-up with off policy");
   cfg_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      dc_on_q |=> $stable(cfg.a2_mask) && $stable(pu_q) && $stable(cfg.a1_sel) &&
                  $stable(cfg.st_sel) && $stable(sb_action_q))
      else $error("configuration changed while output on");
   upd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(a1_d) |=> alarm1_q == $past(a1_d)) else $error("alarm1 late");
   a1_pwr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cfg.a1_sel == apar_pkg::APAR_A1_PWR |=> alarm1_q == $past(s2_q[2]))
      else $error("first alarm power fail selection wrong");
   sb_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !analog_remote && sb_rise && !power_up && !local_on_req |=> !dc_on_q)
      else $error("standby input did not switch output off");
   // under analog remote control the standby pin has no say over the output
   remote_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      analog_remote && !power_up && !local_off_req && !local_on_req |=> $stable(dc_on_q))
      else $error("standby pin acted under analog remote control");
   // a local switch-off forgets the earlier switch-on, so standby cannot restore it
   off_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      local_off_req && !power_up |=> !dc_on_q && !was_on_q)
      else $error("local switch-off not taken");
   pu_restore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      power_up && pu_q == apar_pkg::APAR_PU_RESTORE |=> dc_on_q == $past(last_dc_state))
      else $error("output not restored at power-up");
   // a held write strobe while on keeps the refusal flag high, one cycle per attempt
   rej_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> cfg_reject_q == $past(cfg_we && dc_on_q))
      else $error("refused write not flagged");
   locked_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> cfg_locked_q == $past(dc_on_q))
      else $error("lock flag does not follow output state");
   a2_upd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(a2_d) |=> alarm2_q == $past(a2_d))
      else $error("alarm2 late");
   st_upd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(st_d) |=> status3_q == $past(st_d))
      else $error("status3 late");

   // covers for the main scenarios
   sb_off_c: cover property (@(posedge sys_clk) dc_on_q ##1 !dc_on_q && !analog_remote);
   sb_on_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      sb_fall && was_on_q && sb_action_q == apar_pkg::APAR_SB_ON_OFF);
   rej_c: cover property (@(posedge sys_clk) cfg_reject_q);
   sb_remote_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      analog_remote && sb_rise && dc_on_q);
   pu_rest_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      power_up && pu_q == apar_pkg::APAR_PU_RESTORE && last_dc_state);
endmodule

// file: apar_pkg.sv
// apar_pkg: constants and types for the analog port alarm routing block
// assumes a single 100 MHz system clock and a synchronous active-high reset
// Operation
// - off-only standby action never switches output on
// - on/off action restores only a previously-on output
// - first alarm defaults to overtemperature OR power fail
// - first alarm selector: temperature, power fail, both
// - second alarm defaults overvoltage; seven subset settings
// - second alarm is OR of selected alarms
// - third status defaults to constant voltage regulation
// - third status may show DC output state
// - power-up policy off or restore; default off
// - configuration changes only while output is off
package apar_pkg;
   typedef enum logic [1:0] {APAR_A1_TEMP, APAR_A1_PWR, APAR_A1_BOTH} apar_a1_sel_e;
   typedef enum logic {APAR_SB_OFF_ONLY, APAR_SB_ON_OFF} apar_sb_action_e;
   typedef enum logic {APAR_ST_REGULATION, APAR_ST_DC_STATUS} apar_st_sel_e;
   typedef enum logic {APAR_PU_OFF, APAR_PU_RESTORE} apar_pu_e;
   // second alarm mask bits: [0] overvoltage, [1] overcurrent, [2] overpower
   localparam int          APAR_A2_OV_BIT   = 0;
   localparam int          APAR_A2_OC_BIT   = 1;
   localparam int          APAR_A2_OP_BIT   = 2;
   localparam logic [2:0]  APAR_A2_RESET    = 3'h1;
   localparam apar_a1_sel_e    APAR_A1_RESET = APAR_A1_BOTH;
   localparam apar_sb_action_e APAR_SB_RESET = APAR_SB_OFF_ONLY;
   localparam apar_st_sel_e    APAR_ST_RESET = APAR_ST_REGULATION;
   localparam apar_pu_e        APAR_PU_RESET = APAR_PU_OFF;
endpackage

// file: apar_cfg_if.sv
// apar_cfg_if: carries the live configuration from the top to the alarm mux
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface apar_cfg_if;
   apar_pkg::apar_a1_sel_e a1_sel;
   logic [2:0]             a2_mask;
   apar_pkg::apar_st_sel_e st_sel;
   modport src (output a1_sel, output a2_mask, output st_sel);
   modport dst (input a1_sel, input a2_mask, input st_sel);
endinterface

// file: apar_mux.sv
// apar_mux: combinational alarm and status selection
// assumes inputs are already synchronised to sys_clk
`timescale 1ns/1ps
module apar_mux (
   // configuration
   apar_cfg_if.dst   cfg,
   // alarm and state inputs
   input  wire logic temp_alm,
   input  wire logic pwr_alm,
   input  wire logic ov,
   input  wire logic oc,
   input  wire logic op,
   input  wire logic volt_reg,
   input  wire logic dc_on,
   // selected levels
   output logic      a1,
   output logic      a2,
   output logic      st
);
   // mask bit positions are named once, so the mask and the alarms cannot drift apart
   logic [2:0] prot;

   assign prot[apar_pkg::APAR_A2_OV_BIT] = ov;
   assign prot[apar_pkg::APAR_A2_OC_BIT] = oc;
   assign prot[apar_pkg::APAR_A2_OP_BIT] = op;

   always_comb begin
      unique case (cfg.a1_sel)
         apar_pkg::APAR_A1_TEMP: a1 = temp_alm;
         apar_pkg::APAR_A1_PWR:  a1 = pwr_alm;
         apar_pkg::APAR_A1_BOTH: a1 = temp_alm | pwr_alm;
         default:                a1 = temp_alm | pwr_alm;
      endcase
   end
   assign a2 = |(cfg.a2_mask & prot);
   assign st = (cfg.st_sel == apar_pkg::APAR_ST_DC_STATUS) ? dc_on : volt_reg;
endmodule

// file: apar_ext_eq.sv
// apar_ext_eq: control equipment on the analog port, alarm and standby pins
// assumes requests come from the bench in the sys_clk domain
`timescale 1ns/1ps
module apar_ext_eq (
   // clock
   input  wire logic       sys_clk,
   // bench requests: {cv, op, oc, ov, pf, ot} and standby level
   input  wire logic [5:0] lvl_req,
   input  wire logic       sb_req,
   // pins toward the block
   output logic [5:0]      alarm_pin = 6'h00,
   output logic            sb_pin = 1'b0
);
   // pins move a cycle late, so the block never sees them in step with the bench
   always @(posedge sys_clk) begin
      alarm_pin <= lvl_req;
      sb_pin    <= sb_req;
   end
endmodule

// file: tb_top.sv
// tb_top: self-checking bench for apar_top with a queue of expected outputs
// assumes apar_top settles any pin change within six clock edges
`timescale 1ns/1ps
module tb_top;
   logic       sys_clk = 1'b0, sys_rst = 1'b1, cfg_we = 1'b0, cfg_st_sel = 1'b0;
   logic       cfg_sb_action = 1'b0, cfg_pu_policy = 1'b0, sb = 1'b0, chk = 1'b0;
   logic       on_req = 1'b0, off_req = 1'b0, remote = 1'b0, pwr_up = 1'b0, last_st = 1'b0;
   logic [1:0] cfg_a1_sel = 2'h0, m_a1 = 2'h2;
   logic [2:0] cfg_a2_mask = 3'h0, m_a2 = 3'h1;
   logic [5:0] lvl = 6'h00, apin;
   logic       m_st = 1'b0, m_dc = 1'b0, sb_pin;
   logic       dc_on_q, alarm1_q, alarm2_q, status3_q, cfg_locked_q;
   logic       cfg_reject_q, we_seen = 1'b0;
   logic [4:0] outs;
   logic [4:0] exp_q[$];
   logic       rej_q[$];
   logic [7:0] rnd = 8'h5C;
   int         n_errors = 0, n_tests = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   apar_ext_eq apar_ext_eq_i (.sys_clk(sys_clk), .lvl_req(lvl), .sb_req(sb),
      .alarm_pin(apin), .sb_pin(sb_pin));
   apar_top apar_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_we(cfg_we),
      .cfg_a1_sel(cfg_a1_sel), .cfg_a2_mask(cfg_a2_mask), .cfg_st_sel(cfg_st_sel),
      .cfg_sb_action(cfg_sb_action), .cfg_pu_policy(cfg_pu_policy), .local_on_req(on_req),
      .local_off_req(off_req), .analog_remote(remote), .power_up(pwr_up),
      .last_dc_state(last_st), .remote_standby_input(sb_pin),
      .overtemperature_alarm(apin[0]), .power_fail_alarm(apin[1]),
      .overvoltage_alarm(apin[2]), .overcurrent_alarm(apin[3]), .overpower_alarm(apin[4]),
      .constant_voltage_regulation(apin[5]), .dc_on_q(dc_on_q), .alarm1_q(alarm1_q),
      .alarm2_q(alarm2_q), .status3_q(status3_q), .cfg_locked_q(cfg_locked_q),
      .cfg_reject_q(cfg_reject_q));
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // expected {dc_on, alarm1, alarm2, status3, locked} from the bench's own model
   function automatic logic [4:0] expv();
      logic a1;
      a1 = (m_a1 == 2'h0) ? lvl[0] : (m_a1 == 2'h1) ? lvl[1] : (lvl[0] | lvl[1]);
      return {m_dc, a1, |(m_a2 & lvl[4:2]), m_st ? m_dc : lvl[5], m_dc};
   endfunction
   task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic note();
      repeat (6) @(posedge sys_clk);
      exp_q.push_back(expv());
      chk <= 1'b1;
      @(posedge sys_clk);
      chk <= 1'b0;
   endtask
   // writes while on are refused, so the model keeps its fields then
   task automatic wr(input logic [1:0] a1, input logic [2:0] a2, input logic st,
                     input logic sba, input logic pu);
      cfg_a1_sel <= a1;
      cfg_a2_mask <= a2;
      cfg_st_sel <= st;
      cfg_sb_action <= sba;
      cfg_pu_policy <= pu;
      cfg_we <= 1'b1;
      rej_q.push_back(m_dc);
      @(posedge sys_clk);
      cfg_we <= 1'b0;
      if (!m_dc && a1 != 2'h3) m_a1 = a1;
      if (!m_dc && a2 != 3'h0) m_a2 = a2;
      if (!m_dc) m_st = st;
   endtask
   // one-cycle pulse on {power_up, local_off_req, local_on_req}
   task automatic ctl(input logic [2:0] v);
      {pwr_up, off_req, on_req} <= v;
      @(posedge sys_clk);
      {pwr_up, off_req, on_req} <= 3'h0;
   endtask
   task automatic stop_test();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   assign outs = {dc_on_q, alarm1_q, alarm2_q, status3_q, cfg_locked_q};
   always @(posedge sys_clk) we_seen <= cfg_we;
   always @(negedge sys_clk) begin
      if (chk === 1'b1) check("outputs", outs, exp_q.pop_front());
      if (we_seen === 1'b1)
         check("reject", {4'h0, cfg_reject_q}, {4'h0, rej_q.pop_front()});
      else if (cfg_reject_q !== 1'b0)
         check("reject idle", {4'h0, cfg_reject_q}, 5'h00);
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      note();
      for (int i = 0; i < 6; i++) begin
         lvl <= 6'(1 << i);
         note();
      end
      $display("test defaults done");
      for (int i = 0; i < 22; i++) begin
         rnd = lfsr(rnd);
         if (i == 21) wr(2'h3, 3'h0, rnd[7], 1'b0, 1'b0);
         else wr(2'(i % 3), 3'(i % 7 + 1), rnd[7], 1'b0, 1'b0);
         lvl <= rnd[5:0];
         note();
      end
      $display("test routing done");
      lvl <= 6'h00;
      wr(2'h0, 3'h2, 1'b1, 1'b0, 1'b0);
      ctl(3'h1);
      m_dc = 1'b1;
      note();
      wr(2'h1, 3'h4, 1'b0, 1'b1, 1'b1);
      note();
      sb <= 1'b1;
      m_dc = 1'b0;
      note();
      sb <= 1'b0;
      note();
      $display("test off-only done");
      wr(2'h0, 3'h2, 1'b1, 1'b1, 1'b0);
      ctl(3'h1);
      sb <= 1'b1;
      note();
      sb <= 1'b0;
      m_dc = 1'b1;
      note();
      ctl(3'h2);
      m_dc = 1'b0;
      sb <= 1'b1;
      note();
      sb <= 1'b0;
      note();
      ctl(3'h1);
      m_dc = 1'b1;
      remote <= 1'b1;
      sb <= 1'b1;
      note();
      sb <= 1'b0;
      note();
      remote <= 1'b0;
      ctl(3'h2);
      m_dc = 1'b0;
      $display("test standby done");
      wr(2'h0, 3'h2, 1'b1, 1'b1, 1'b1);
      last_st <= 1'b1;
      ctl(3'h4);
      m_dc = 1'b1;
      note();
      ctl(3'h2);
      m_dc = 1'b0;
      wr(2'h0, 3'h2, 1'b1, 1'b1, 1'b0);
      ctl(3'h4);
      note();
      $display("test power-up done");
      lvl <= 6'h26;
      ctl(3'h1);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      m_a1 = 2'h2;
      m_a2 = 3'h1;
      m_st = 1'b0;
      note();
      $display("test reset done");
      stop_test();
   end
endmodule
